// *** hw/dio_pkg.sv ***
// Package with register map, field positions and timing constants of the digital I/O block.
package dio_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] DIO_BIDIR_DIR   = 4'h0;
  localparam logic [3:0] DIO_BIDIR_OUT   = 4'h1;
  localparam logic [3:0] DIO_BIDIR_IN    = 4'h2;
  localparam logic [3:0] DIO_DED_OUT     = 4'h3;
  localparam logic [3:0] DIO_OVL_STAT    = 4'h4;
  localparam logic [3:0] DIO_INPUTS      = 4'h5;
  localparam logic [3:0] DIO_CNT0        = 4'h6;
  localparam logic [3:0] DIO_CNT1        = 4'h7;
  localparam logic [3:0] DIO_ENC_POS     = 4'h8;
  localparam logic [3:0] DIO_ENC_CTRL    = 4'h9;
  localparam logic [3:0] DIO_IRQ_STAT    = 4'ha;
  localparam logic [3:0] DIO_IRQ_MASK    = 4'hb;
  localparam logic [3:0] DIO_CNT_CLR     = 4'hc;

  // Overload and fault status field positions.
  localparam int OVL_BIDIR_BIT  = 0;
  localparam int OVL_DED_BIT    = 1;
  localparam int OVL_FAULT_BIT  = 2;

  // Clear register field positions.
  localparam int CLR_CNT0_BIT   = 0;
  localparam int CLR_CNT1_BIT   = 1;
  localparam int CLR_ENC_BIT    = 2;

  // Interrupt status field positions.
  localparam int IRQ_IN4_BIT    = 0;
  localparam int IRQ_IN5_BIT    = 1;
  localparam int IRQ_OVL_B_BIT  = 2;
  localparam int IRQ_OVL_D_BIT  = 3;
  localparam int IRQ_ZERO_BIT   = 4;
  localparam int IRQ_WIDTH      = 5;

  // Encoder control field positions.
  localparam int ENC_ZERO_EN_BIT = 0;

  // Input pin roles.
  localparam int IN_CNT0   = 0;
  localparam int IN_DIR0   = 1;
  localparam int IN_CNT1   = 2;
  localparam int IN_DIR1   = 3;
  localparam int IN_INT0   = 4;
  localparam int IN_INT1   = 5;
  localparam int IN_ENC_A  = 6;
  localparam int IN_ENC_B  = 7;
  localparam int IN_ENC_N  = 8;
  localparam int IN_ENC_NA = 9;

  // Reset values: every bidirectional channel starts as an output.
  localparam logic [7:0] BIDIR_DIR_RST = 8'hff;
  localparam logic [7:0] OUT_RST       = 8'h00;

  // Clock rate and highest counting rate.
  localparam int CLK_KHZ       = 125000;
  localparam int CNT_MAX_KHZ   = 50;
  localparam int CNT_MIN_CYC   = CLK_KHZ / CNT_MAX_KHZ;

endpackage : dio_pkg

// *** hw/dio_sync.sv ***
// Two-stage synchroniser for a bus of asynchronous pin inputs.
module dio_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // dio_sync

// *** hw/dio_top.sv ***
// Digital I/O block with bidirectional channels, dedicated outputs, counters and encoder.
//
// What this block does
// - After reset all eight bidirectional channels drive as outputs.
// - Software selects input or output direction for each bidirectional channel.
// - Overload on any driven bidirectional channel switches off that whole group.
// - Overload on any dedicated output switches off all eight dedicated outputs.
// - Overload per output group is latched and readable by software.
// - Driver short-circuit or reverse-polarity faults are reported as a fault condition.
// - Ten dedicated inputs are readable; some also serve special functions.
// - Two independent counters count pulses up to 50 kHz each.
// - Input 1 sets counter 0 direction, input 3 sets counter 1 direction.
// - Inputs 4 and 5 can each raise an interrupt to software.
// - Encoder uses inputs 6, 7 as A, B, 8 as zero mark, 9 as qualifier.
//
// The implementer's own choices: strobed register access and the register addresses.
module dio_top
  import dio_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  input  wire logic [3:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  input  wire logic [7:0]  BIDIR_CHANNELS_I,
  output logic      [7:0]  BIDIR_CHANNELS_O,
  output logic      [7:0]  BIDIR_CHANNELS_OE_O,
  input  wire logic [7:0]  BIDIR_OVERLOAD_I,
  output logic      [7:0]  DEDICATED_OUTPUTS_O,
  input  wire logic [7:0]  DEDICATED_OVERLOAD_I,
  input  wire logic        DEDICATED_FAULT_I,
  input  wire logic [9:0]  DIG_IN_I,
  output logic             IRQ_O
);

  // Elaboration check: a counter needs two bits at least and must fit one read word.
  if (CNT_W < 2 || CNT_W > 32)
  begin : g_cnt_w_check
    $error("CNT_W must lie between 2 and 32.");
  end

  // Synchronised copies of all pin inputs.
  // Every pin passes two flip-flops, so an edge seen below lags its pin by two clocks.
  // The pins are slow field signals, so this latency costs nothing at the counting rate.
  logic [9:0] din_s;
  logic [7:0] bin_s;
  logic [7:0] bovl_s;
  logic [7:0] dovl_s;
  logic       dflt_s;
  logic [9:0] din_prev_q;

  dio_sync #(.WIDTH(10)) u_sync_din (
    .clk_i   (SYS_CLK_I),
    .srst_i  (SRST_I),
    .async_i (DIG_IN_I),
    .sync_o  (din_s)
  );

  dio_sync #(.WIDTH(25)) u_sync_misc (
    .clk_i   (SYS_CLK_I),
    .srst_i  (SRST_I),
    .async_i ({DEDICATED_FAULT_I, DEDICATED_OVERLOAD_I, BIDIR_OVERLOAD_I, BIDIR_CHANNELS_I}),
    .sync_o  ({dflt_s, dovl_s, bovl_s, bin_s})
  );

  // Software registers.
  logic [7:0]           dir_q;
  logic [7:0]           bout_q;
  logic [7:0]           dout_q;
  logic [1:0]           ovl_q;
  logic                 fault_q;
  logic [IRQ_WIDTH-1:0] irq_stat_q;
  logic [IRQ_WIDTH-1:0] irq_mask_q;
  logic                 zero_en_q;
  logic [CNT_W-1:0]     cnt0_q;
  logic [CNT_W-1:0]     cnt1_q;
  logic [31:0]          enc_q;
  logic [31:0]          rdata_q;
  logic [1:0]           quad_q;

  // Address decode.
  wire wr_dir  = REG_WR_I && (REG_ADDR_I == DIO_BIDIR_DIR);
  wire wr_bout = REG_WR_I && (REG_ADDR_I == DIO_BIDIR_OUT);
  wire wr_dout = REG_WR_I && (REG_ADDR_I == DIO_DED_OUT);
  wire wr_ovl  = REG_WR_I && (REG_ADDR_I == DIO_OVL_STAT);
  wire wr_encc = REG_WR_I && (REG_ADDR_I == DIO_ENC_CTRL);
  wire wr_ists = REG_WR_I && (REG_ADDR_I == DIO_IRQ_STAT);
  wire wr_imsk = REG_WR_I && (REG_ADDR_I == DIO_IRQ_MASK);
  wire wr_cclr = REG_WR_I && (REG_ADDR_I == DIO_CNT_CLR);

  // Write-one-to-clear strobes, one for each field of the overload register.
  wire clr_ovl_b = wr_ovl && REG_WDATA_I[OVL_BIDIR_BIT];
  wire clr_ovl_d = wr_ovl && REG_WDATA_I[OVL_DED_BIT];
  wire clr_fault = wr_ovl && REG_WDATA_I[OVL_FAULT_BIT];

  // Clear strobes of the counter clear register; several may be set in one write.
  wire clr_cnt0  = wr_cclr && REG_WDATA_I[CLR_CNT0_BIT];
  wire clr_cnt1  = wr_cclr && REG_WDATA_I[CLR_CNT1_BIT];
  wire clr_enc   = wr_cclr && REG_WDATA_I[CLR_ENC_BIT];

  // Interrupt status bits that software writes back as ones to clear them.
  wire [IRQ_WIDTH-1:0] irq_clr = {IRQ_WIDTH{wr_ists}} & REG_WDATA_I[IRQ_WIDTH-1:0];

  // Edge detection on synchronised inputs, no filtering applied.
  // A bouncing contact therefore counts every bounce; filtering is left to software.
  wire [9:0] rise = din_s & ~din_prev_q;

  // group overload
  // Overload is only seen on channels that are currently driven.
  // An overload report on an input channel is ignored, since no driver is on there.
  wire bidir_ovl_ev = |(bovl_s & dir_q);
  wire ded_ovl_ev   = |dovl_s;

  // counting direction
  // Down when the direction input is high, up when low.
  // Both counters share this step, so both read their own direction input with the same polarity.
  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v, input logic dn);
    step = dn ? v - CNT_W'(1) : v + CNT_W'(1);
  endfunction

  // quadrature decode
  // Gray-sequence step: +1 forward, -1 reverse, 0 for none or illegal jumps.
  // A jump across two states means a missed step; it is dropped rather than guessed.
  wire [1:0] quad_now = {din_s[IN_ENC_A], din_s[IN_ENC_B]};
  wire       enc_fwd  = (quad_q == 2'h0 && quad_now == 2'h2) ||
                        (quad_q == 2'h2 && quad_now == 2'h3) ||
                        (quad_q == 2'h3 && quad_now == 2'h1) ||
                        (quad_q == 2'h1 && quad_now == 2'h0);
  wire       enc_rev  = (quad_q == 2'h0 && quad_now == 2'h1) ||
                        (quad_q == 2'h1 && quad_now == 2'h3) ||
                        (quad_q == 2'h3 && quad_now == 2'h2) ||
                        (quad_q == 2'h2 && quad_now == 2'h0);
  // zero mark
  // Zero mark resets position only when the qualifier input is high and enabled.
  wire       enc_zero = zero_en_q && rise[IN_ENC_N] && din_s[IN_ENC_NA];

  // interrupt events
  // Hardware-set events, collected into the sticky status.
  // Overload events fire once, in the cycle in which the group flag first sets.
  logic [IRQ_WIDTH-1:0] irq_ev;
  always_comb
  begin
    irq_ev                = '0;
    irq_ev[IRQ_IN4_BIT]   = rise[IN_INT0];
    irq_ev[IRQ_IN5_BIT]   = rise[IN_INT1];
    irq_ev[IRQ_OVL_B_BIT] = bidir_ovl_ev & ~ovl_q[OVL_BIDIR_BIT];
    irq_ev[IRQ_OVL_D_BIT] = ded_ovl_ev & ~ovl_q[OVL_DED_BIT];
    irq_ev[IRQ_ZERO_BIT]  = enc_zero;
  end

  // direction select
  // Direction and output values; reset makes every channel a driven output.
  // A channel switched to input stops driving at the next clock edge.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      dir_q  <= BIDIR_DIR_RST;
      bout_q <= OUT_RST;
      dout_q <= OUT_RST;
    end
    else
    begin
      if (wr_dir)
        dir_q <= REG_WDATA_I[7:0];
      if (wr_bout)
        bout_q <= REG_WDATA_I[7:0];
      if (wr_dout)
        dout_q <= REG_WDATA_I[7:0];
    end
  end

  // driver fault
  // Next overload and fault flags; a new event wins over a clear in the same cycle.
  // The events are levels, so a clear only sticks once the cause has gone away.
  logic [1:0] ovl_d;
  always_comb
  begin
    ovl_d                = ovl_q;
    ovl_d[OVL_BIDIR_BIT] = bidir_ovl_ev | (ovl_q[OVL_BIDIR_BIT] & ~clr_ovl_b);
    ovl_d[OVL_DED_BIT]   = ded_ovl_ev | (ovl_q[OVL_DED_BIT] & ~clr_ovl_d);
  end

  wire fault_d = dflt_s | (fault_q & ~clr_fault);

  // Overload and fault flags are sticky until software clears them.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      ovl_q   <= 2'h0;
      fault_q <= 1'b0;
    end
    else
    begin
      ovl_q   <= ovl_d;
      fault_q <= fault_d;
    end
  end

  // group shutdown
  // A latched overload holds its whole group off until software clears it.
  // A driver fault blanks the dedicated group in the same way as an overload.
  assign BIDIR_CHANNELS_O    = ovl_q[OVL_BIDIR_BIT] ? 8'h00 : (bout_q & dir_q);
  assign BIDIR_CHANNELS_OE_O = ovl_q[OVL_BIDIR_BIT] ? 8'h00 : dir_q;
  assign DEDICATED_OUTPUTS_O = (ovl_q[OVL_DED_BIT] | fault_q) ? 8'h00 : dout_q;

  // paired direction
  // Each count edge steps its counter, direction taken from the paired input.
  // A clear wins over a count edge in the same cycle; the counters wrap silently,
  // so software must read them often enough to tell a wrap from a jump.
  wire [CNT_W-1:0] cnt0_d = clr_cnt0      ? {CNT_W{1'b0}} :
                            rise[IN_CNT0] ? step(cnt0_q, din_s[IN_DIR0]) : cnt0_q;
  wire [CNT_W-1:0] cnt1_d = clr_cnt1      ? {CNT_W{1'b0}} :
                            rise[IN_CNT1] ? step(cnt1_q, din_s[IN_DIR1]) : cnt1_q;

  // Counter registers.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      cnt0_q <= '0;
      cnt1_q <= '0;
    end
    else
    begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  // encoder position
  // Next position; the zero mark or a clear wins over a quadrature step.
  // The position wraps silently at the ends of its 32-bit range.
  wire [31:0] enc_d = (enc_zero || clr_enc) ? 32'h0 :
                      enc_fwd               ? enc_q + 32'h1 :
                      enc_rev               ? enc_q - 32'h1 : enc_q;

  // Encoder position follows the quadrature steps.
  // The previous pin copies reset to the idle level so that no false edge follows reset.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      enc_q      <= '0;
      quad_q     <= 2'h0;
      zero_en_q  <= 1'b0;
      din_prev_q <= '0;
    end
    else
    begin
      quad_q     <= quad_now;
      din_prev_q <= din_s;
      if (wr_encc)
        zero_en_q <= REG_WDATA_I[ENC_ZERO_EN_BIT];
      enc_q      <= enc_d;
    end
  end

  // interrupt status
  // Next status; an event in the cycle of its clear keeps the bit set.
  wire [IRQ_WIDTH-1:0] irq_stat_d = irq_ev | (irq_stat_q & ~irq_clr);

  // Sticky status, write one to clear, set wins over clear.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (wr_imsk)
        irq_mask_q <= REG_WDATA_I[IRQ_WIDTH-1:0];
    end
  end

  // The level output follows status and mask with no further delay.
  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // input readback
  // Read multiplexer; unmapped addresses read zero.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (REG_ADDR_I)
      DIO_BIDIR_DIR: rd_mux = {24'h0, dir_q};
      DIO_BIDIR_OUT: rd_mux = {24'h0, bout_q};
      DIO_BIDIR_IN:  rd_mux = {24'h0, bin_s};
      DIO_DED_OUT:   rd_mux = {24'h0, dout_q};
      DIO_OVL_STAT:  rd_mux = {29'h0, fault_q, ovl_q};
      DIO_INPUTS:    rd_mux = {22'h0, din_s};
      DIO_CNT0:      rd_mux = 32'(cnt0_q);
      DIO_CNT1:      rd_mux = 32'(cnt1_q);
      DIO_ENC_POS:   rd_mux = enc_q;
      DIO_ENC_CTRL:  rd_mux = {31'h0, zero_en_q};
      DIO_IRQ_STAT:  rd_mux = {27'h0, irq_stat_q};
      DIO_IRQ_MASK:  rd_mux = {27'h0, irq_mask_q};
      default:       rd_mux = 32'h0;
    endcase
  end

  // Read data stand one cycle after the read strobe and only then.
  // Zero outside the answer cycle lets several slaves share one read bus by an OR.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SRST_I)
      rdata_q <= 32'h0;
    else
      rdata_q <= REG_RD_I ? rd_mux : 32'h0;
  end

  assign REG_RDATA_O = rdata_q;

endmodule // dio_top

// *** tb/dio_checker.sv ***
// Concurrent checks on the ports of the digital I/O block.
module dio_checker
  import dio_pkg::*;
(
  input wire logic        SYS_CLK_I,
  input wire logic        SRST_I,
  input wire logic [3:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic [7:0]  BIDIR_CHANNELS_O,
  input wire logic [7:0]  BIDIR_CHANNELS_OE_O,
  input wire logic [7:0]  BIDIR_OVERLOAD_I,
  input wire logic [7:0]  DEDICATED_OUTPUTS_O,
  input wire logic [7:0]  DEDICATED_OVERLOAD_I,
  input wire logic        DEDICATED_FAULT_I,
  input wire logic [9:0]  DIG_IN_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  // Steps of a quiet input read and of an overload that has gone away.
  sequence s_quiet_rd;
    $stable(DIG_IN_I)[*4] ##0 (REG_RD_I && REG_ADDR_I == DIO_INPUTS);
  endsequence
  sequence s_ded_gone;
    (|DEDICATED_OVERLOAD_I)[*2] ##1 (DEDICATED_OVERLOAD_I == 8'h00 && !REG_WR_I);
  endsequence
  a_reset_all_out:
  assert property (disable iff (1'b0) SRST_I |=> BIDIR_CHANNELS_OE_O == BIDIR_DIR_RST)
    else $error("Channels are not outputs after reset.");
  a_bidir_out_drive:
  assert property (REG_WR_I && REG_ADDR_I == DIO_BIDIR_OUT && BIDIR_CHANNELS_OE_O == 8'hff
    && BIDIR_OVERLOAD_I == 8'h00 |=> BIDIR_CHANNELS_O == $past(REG_WDATA_I[7:0]))
    else $error("Channel drive does not follow the write.");
  a_dir_write:
  assert property (REG_WR_I && REG_ADDR_I == DIO_BIDIR_DIR && BIDIR_CHANNELS_OE_O != 8'h00
    && BIDIR_OVERLOAD_I == 8'h00 |=> BIDIR_CHANNELS_OE_O == $past(REG_WDATA_I[7:0]))
    else $error("Direction does not follow the write.");
  a_bidir_group_off:
  assert property (|(BIDIR_OVERLOAD_I & BIDIR_CHANNELS_OE_O) |-> ##[1:5]
    (BIDIR_CHANNELS_OE_O == 8'h00 && BIDIR_CHANNELS_O == 8'h00))
    else $error("Channel group not switched off on overload.");
  a_ded_group_off:
  assert property ((|DEDICATED_OVERLOAD_I) || DEDICATED_FAULT_I |-> ##[1:5]
    DEDICATED_OUTPUTS_O == 8'h00) else $error("Dedicated outputs not switched off.");
  a_ovl_latched:
  assert property (s_ded_gone |=> DEDICATED_OUTPUTS_O == 8'h00)
    else $error("Overload shutdown did not stay latched.");
  a_inputs_read:
  assert property (s_quiet_rd |=> REG_RDATA_O == {22'h0, $past(DIG_IN_I)})
    else $error("Input read does not match the pins.");
  a_rdata_idle:
  assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
    else $error("Read data outside the answer cycle.");
  a_unmapped_zero:
  assert property (REG_RD_I && REG_ADDR_I > DIO_CNT_CLR |=> REG_RDATA_O == 32'h0)
    else $error("Unmapped read is not zero.");
endmodule // dio_checker

bind dio_top dio_checker dio_checker_inst (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .BIDIR_CHANNELS_O(BIDIR_CHANNELS_O),
  .BIDIR_CHANNELS_OE_O(BIDIR_CHANNELS_OE_O), .BIDIR_OVERLOAD_I(BIDIR_OVERLOAD_I),
  .DEDICATED_OUTPUTS_O(DEDICATED_OUTPUTS_O), .DEDICATED_OVERLOAD_I(DEDICATED_OVERLOAD_I),
  .DEDICATED_FAULT_I(DEDICATED_FAULT_I), .DIG_IN_I(DIG_IN_I));

// *** tb/dio_field_model.sv ***
// Field side model: sensors, loads with optional shorts, and channel wiring.
module dio_field_model (
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ded_i,
  input  wire logic [7:0] sense_i,
  input  wire logic [7:0] bshort_i,
  input  wire logic [7:0] dshort_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] bovl_o,
  output logic      [7:0] dovl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin shows the block's drive where enabled, else the sensor level.
  assign pin_o  = (oe_i & drive_i) | (~oe_i & sense_i);
  // A shorted load reports overload only while it is driven high.
  assign bovl_o = bshort_i & oe_i & drive_i;
  assign dovl_o = dshort_i & ded_i;
endmodule // dio_field_model

// *** tb/testbench.sv ***
// Self-checking bench for the digital I/O block.
module testbench
  import dio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        fault = 1'b0;
  logic [9:0]  din = 10'h000;
  logic [7:0]  sense = 8'h00, bsh = 8'h00, dsh = 8'h00;
  logic [7:0]  bpin, bout, boe, bovl, dout, dovl;
  logic [31:0] rdata;
  logic        irq;
  logic [1:0]  quad [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
  int          errors = 0;
  int          n_tests = 0;
  int          i;
  // Free-running clock of 8 ns.
  always #4 clk = ~clk;
  dio_top dio_top_inst (.SYS_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .BIDIR_CHANNELS_I(bpin), .BIDIR_CHANNELS_O(bout), .BIDIR_CHANNELS_OE_O(boe),
    .BIDIR_OVERLOAD_I(bovl), .DEDICATED_OUTPUTS_O(dout), .DEDICATED_OVERLOAD_I(dovl),
    .DEDICATED_FAULT_I(fault), .DIG_IN_I(din), .IRQ_O(irq));
  dio_field_model dio_field_model_inst (.drive_i(bout), .oe_i(boe), .ded_i(dout),
    .sense_i(sense), .bshort_i(bsh), .dshort_i(dsh), .pin_o(bpin), .bovl_o(bovl),
    .dovl_o(dovl));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] ex, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, ex, rdata);
  endtask
  // no bounce
  // One clean pulse at the highest counting rate; sensors give no bounce.
  task automatic pulse(input int b);
    din[b] <= 1'b1;
    wt(CNT_MIN_CYC / 2);
    din[b] <= 1'b0;
    wt(CNT_MIN_CYC / 2);
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog that ends a hung run.
  initial
  begin
    wt(100000);
    errors++;
    end_of_test;
  end
  // Main sequence of register calls with expected values.
  initial
  begin
    wt(2);
    srst <= 1'b0;
    rd_reg(DIO_BIDIR_DIR, 32'hff, "dir");
    chk("oe", 32'hff, {24'h0, boe});
    din <= 10'h3c3;
    wt(4);
    rd_reg(DIO_INPUTS, 32'h3c3, "inputs");
    din <= 10'h000;
    for (i = 4; i < 6; i++)
    begin
      din[i] <= 1'b1;
      wt(4);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr_reg(DIO_IRQ_MASK, 32'h1 << (i - 4));
      chk("irq", 32'h1, {31'h0, irq});
      wr_reg(DIO_IRQ_STAT, 32'h3);
      chk("irq clear", 32'h0, {31'h0, irq});
      din[i] <= 1'b0;
    end
    wr_reg(DIO_BIDIR_OUT, 32'h01);
    wr_reg(DIO_BIDIR_DIR, 32'h0f);
    sense <= 8'h5a;
    wt(4);
    rd_reg(DIO_BIDIR_IN, 32'h51, "pins");
    wr_reg(DIO_IRQ_MASK, 32'h1f);
    bsh <= 8'h01;
    wt(6);
    bsh <= 8'h00;
    chk("oe off", 32'h0, {24'h0, boe});
    chk("irq ovl", 32'h1, {31'h0, irq});
    rd_reg(DIO_OVL_STAT, 32'h1, "ovl bidir");
    wr_reg(DIO_OVL_STAT, 32'h1);
    wr_reg(DIO_IRQ_STAT, 32'h1f);
    chk("oe back", 32'h0f, {24'h0, boe});
    wr_reg(DIO_CNT_CLR, 32'h7);
    for (i = 0; i < 3; i++)
      pulse(IN_CNT0);
    din[IN_DIR0] <= 1'b1;
    din[IN_DIR1] <= 1'b1;
    pulse(IN_CNT0);
    pulse(IN_CNT1);
    pulse(IN_CNT1);
    rd_reg(DIO_CNT0, 32'h2, "cnt0");
    rd_reg(DIO_CNT1, 32'hfffffffe, "cnt1");
    for (i = 0; i < 5; i++)
    begin
      din[7:6] <= (i < 4) ? quad[i] : 2'b10;
      wt(4);
    end
    din[IN_ENC_N] <= 1'b1;
    wt(4);
    rd_reg(DIO_ENC_POS, 32'h3, "enc pos");
    wr_reg(DIO_ENC_CTRL, 32'h1);
    din[IN_ENC_N] <= 1'b0;
    din[IN_ENC_NA] <= 1'b1;
    wt(4);
    din[IN_ENC_N] <= 1'b1;
    wt(4);
    rd_reg(DIO_ENC_POS, 32'h0, "enc zero");
    rd_reg(DIO_IRQ_STAT, 32'h10, "irq zero");
    wr_reg(DIO_DED_OUT, 32'hff);
    chk("ded", 32'hff, {24'h0, dout});
    dsh <= 8'h80;
    wt(6);
    dsh <= 8'h00;
    chk("ded off", 32'h0, {24'h0, dout});
    rd_reg(DIO_OVL_STAT, 32'h2, "ovl ded");
    wr_reg(DIO_OVL_STAT, 32'h2);
    chk("ded back", 32'hff, {24'h0, dout});
    fault <= 1'b1;
    wt(6);
    chk("ded fault", 32'h0, {24'h0, dout});
    fault <= 1'b0;
    rd_reg(DIO_OVL_STAT, 32'h4, "fault");
    wr_reg(4'he, 32'hffffffff);
    rd_reg(4'hd, 32'h0, "unmapped");
    rd_reg(DIO_BIDIR_DIR, 32'h0f, "dir kept");
    end_of_test;
  end
endmodule // testbench
